// ===== acc_unit_pkg.sv
package acc_unit_pkg;
    // datapath widths and stack depth
    localparam int ACC_W        = 32;
    localparam int WORD_W       = 16;
    localparam int ADDR_W       = 16;
    localparam int BIT_CNT_W    = 6;
    localparam int STACK_DEPTH  = 8;

    // values after reset
    localparam logic [ACC_W-1:0]     ACC_RST   = 32'h0000_0000;
    localparam logic [BIT_CNT_W-1:0] CNT_RST   = 6'h00;
    localparam logic [ADDR_W-1:0]    ADDR_RST  = 16'h0000;
    localparam logic [WORD_W-1:0]    WORD_RST  = 16'h0000;

    // bit count limits for formatted output
    localparam logic [BIT_CNT_W-1:0] BITS_MIN  = 6'h01;
    localparam logic [BIT_CNT_W-1:0] BITS_MAX  = 6'h20;

    // operation codes presented on op_code
    typedef enum logic [3:0] {
        OP_NOP                 = 4'h0,
        OP_LOAD_WORD           = 4'h1,
        OP_LOAD_ADDR           = 4'h2,
        OP_WORD_OUTPUT         = 4'h3,
        OP_FORMATTED_BIT_OUT   = 4'h4,
        OP_INDEXED_WORD_OUTPUT = 4'h5,
        OP_LOW_BYTE_OUTPUT     = 4'h6,
        OP_HIGH_BYTE_OUTPUT    = 4'h7,
        OP_POP                 = 4'h8,
        OP_AND_WORD            = 4'h9,
        OP_AND_WIDE_CONSTANT   = 4'hA
    } op_t;

    // sequencer states
    typedef enum logic [1:0] {
        S_IDLE,
        S_RD,
        S_DATA,
        S_BITS
    } seq_state_t;
endpackage : acc_unit_pkg

// ===== acc_stack.sv
`timescale 1ns/1ns
// accumulator stack: level 0 is the first level
module acc_stack #(
    parameter int DEPTH = acc_unit_pkg::STACK_DEPTH,
    parameter int WIDTH = acc_unit_pkg::ACC_W
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    // control
    input  wire logic             push,
    input  wire logic             pop,
    input  wire logic [WIDTH-1:0] push_data,
    // first level
    output logic      [WIDTH-1:0] top
);
    import acc_unit_pkg::*;

    logic [WIDTH-1:0] lvl_r   [DEPTH];   // stack levels
    logic [WIDTH-1:0] lvl_nxt [DEPTH];   // next levels

    assign top = lvl_r[0];

    // shift down on push, up on pop
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            lvl_nxt[i] = lvl_r[i];
        end
        if (push) begin
            lvl_nxt[0] = push_data;
            for (int i = 1; i < DEPTH; i++) begin
                lvl_nxt[i] = lvl_r[i-1];
            end
        end else if (pop) begin
            // every remaining level moves up one
            for (int i = 0; i < DEPTH-1; i++) begin
                lvl_nxt[i] = lvl_r[i+1];
            end
            lvl_nxt[DEPTH-1] = '0;
        end
    end

    // level registers
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (sys_rst) begin
                lvl_r[i] <= '0;
            end else begin
                lvl_r[i] <= lvl_nxt[i];
            end
        end
    end
endmodule : acc_stack

// ===== accumulator_output_and_logic_unit.sv
`timescale 1ns/1ns
// Contract
// - formatted output writes low N bits serially
// - indexed output writes stack top to base+acc
// - index offset added as plain binary
// - indexed output clears accumulator upper half
// - back-to-back loads push earlier accumulator value
// - load address converts octal operand to binary
// - low byte output writes accumulator bits 7:0
// - high byte output writes accumulator bits 15:8
// - pop moves first level into accumulator
// - word and masks low accumulator half
// - word and updates zero flag
// - wide and masks accumulator with constant
// - wide and updates zero flag
// - wide and updates negative flag from bit31
// - flags hold until next writing operation
// - word output copies low half; loads set zero
module accumulator_output_and_logic_unit #(
    parameter int STACK_LEVELS = acc_unit_pkg::STACK_DEPTH
) (
    // clock and reset
    input  wire logic                               core_clk,
    input  wire logic                               sys_rst,
    // operation request
    input  wire logic                               op_valid,
    input  wire acc_unit_pkg::op_t                  op_code,
    input  wire logic [acc_unit_pkg::ADDR_W-1:0]    op_addr,
    input  wire logic [acc_unit_pkg::ACC_W-1:0]     op_const,
    output logic                                    op_ready_r,
    output logic                                    op_done_r,
    // data word memory
    output logic [acc_unit_pkg::ADDR_W-1:0]         wmem_addr_r,
    output logic                                    wmem_rd_en_r,
    output logic                                    wmem_wr_en_r,
    output logic [acc_unit_pkg::WORD_W-1:0]         wmem_wdata_r,
    input  wire logic [acc_unit_pkg::WORD_W-1:0]    wmem_rdata,
    // discrete bit memory
    output logic [acc_unit_pkg::ADDR_W-1:0]         bmem_addr_r,
    output logic                                    bmem_wr_en_r,
    output logic                                    bmem_wdata_r,
    // accumulator and status
    output logic [acc_unit_pkg::ACC_W-1:0]          acc_r,
    output logic                                    zero_result_flag_r,
    output logic                                    negative_result_flag_r
);
    import acc_unit_pkg::*;

    // octal digits in nibbles packed into binary
    function automatic logic [23:0] octal_to_bin(input logic [31:0] dig);
        logic [23:0] res;
        res = '0;
        for (int i = 0; i < 8; i++) begin
            res[i*3 +: 3] = dig[i*4 +: 3];
        end
        return res;
    endfunction : octal_to_bin

    // zero test used by every zero flag update
    function automatic logic is_zero(input logic [ACC_W-1:0] v);
        return (v == ACC_RST);
    endfunction : is_zero

    // clamp bit count into 1..32
    function automatic logic [BIT_CNT_W-1:0] clamp_bits(input logic [ACC_W-1:0] k);
        logic [BIT_CNT_W-1:0] r;
        r = k[BIT_CNT_W-1:0];
        if (k == ACC_RST) begin
            r = BITS_MIN;
        end else if (k > ACC_W'(BITS_MAX)) begin
            r = BITS_MAX;
        end
        return r;
    endfunction : clamp_bits

    // sequencer state
    seq_state_t             state_r, state_nxt;
    op_t                    op_r, op_nxt;              // latched operation
    logic [BIT_CNT_W-1:0]   cnt_r, cnt_nxt;            // bits already written
    logic [BIT_CNT_W-1:0]   nbits_r, nbits_nxt;        // bits to write
    logic                   last_load_r, last_load_nxt; // previous op was a load
    // output next values
    logic                   ready_nxt, done_nxt;
    logic [ADDR_W-1:0]      waddr_nxt, baddr_nxt;
    logic                   rd_nxt, wr_nxt, bwr_nxt, bdat_nxt;
    logic [WORD_W-1:0]      wdata_nxt;
    logic [ACC_W-1:0]       acc_nxt;
    logic                   zf_nxt, nf_nxt;
    // stack control
    logic                   push, pop;
    logic [ACC_W-1:0]       stack_top;

    acc_stack #(
        .DEPTH (STACK_LEVELS),
        .WIDTH (ACC_W)
    ) u_stack (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .push      (push),
        .pop       (pop),
        .push_data (acc_r),
        .top       (stack_top)
    );

    // next-state and datapath decode
    always_comb begin
        state_nxt     = state_r;
        op_nxt        = op_r;
        cnt_nxt       = cnt_r;
        nbits_nxt     = nbits_r;
        last_load_nxt = last_load_r;
        ready_nxt     = op_ready_r;
        done_nxt      = 1'b0;
        waddr_nxt     = wmem_addr_r;
        rd_nxt        = 1'b0;
        wr_nxt        = 1'b0;
        wdata_nxt     = wmem_wdata_r;
        baddr_nxt     = bmem_addr_r;
        bwr_nxt       = 1'b0;
        bdat_nxt      = bmem_wdata_r;
        acc_nxt       = acc_r;
        zf_nxt        = zero_result_flag_r;     // flags hold otherwise
        nf_nxt        = negative_result_flag_r;
        push          = 1'b0;
        pop           = 1'b0;
        case (state_r)
            S_IDLE: begin
                if (op_valid && op_ready_r) begin
                    op_nxt        = op_code;
                    last_load_nxt = 1'b0;
                    done_nxt      = 1'b1;
                    case (op_code)
                        // operations needing the word memory first
                        OP_LOAD_WORD, OP_AND_WORD, OP_LOW_BYTE_OUTPUT,
                        OP_HIGH_BYTE_OUTPUT: begin
                            waddr_nxt = op_addr;
                            rd_nxt    = 1'b1;
                            ready_nxt = 1'b0;
                            done_nxt  = 1'b0;
                            state_nxt = S_RD;
                            if (op_code == OP_LOAD_WORD) begin
                                // chain judged when the load completes
                                last_load_nxt = last_load_r;
                            end
                        end
                        OP_LOAD_ADDR: begin
                            push          = last_load_r;
                            acc_nxt       = ACC_W'(octal_to_bin(op_const));
                            zf_nxt        = is_zero(acc_nxt);
                            last_load_nxt = 1'b1;
                        end
                        OP_WORD_OUTPUT: begin
                            waddr_nxt = op_addr;
                            wdata_nxt = acc_r[WORD_W-1:0];
                            wr_nxt    = 1'b1;
                        end
                        OP_FORMATTED_BIT_OUT: begin
                            nbits_nxt = clamp_bits(op_const);
                            baddr_nxt = op_addr;
                            bdat_nxt  = acc_r[0];
                            bwr_nxt   = 1'b1;
                            cnt_nxt   = BITS_MIN;
                            if (clamp_bits(op_const) != BITS_MIN) begin
                                ready_nxt = 1'b0;
                                done_nxt  = 1'b0;
                                state_nxt = S_BITS;
                            end
                        end
                        OP_INDEXED_WORD_OUTPUT: begin
                            // binary add, no decimal adjust
                            waddr_nxt = op_addr + acc_r[ADDR_W-1:0];
                            wdata_nxt = stack_top[WORD_W-1:0];
                            wr_nxt    = 1'b1;
                            acc_nxt   = {WORD_RST, acc_r[WORD_W-1:0]};
                        end
                        OP_POP: begin
                            pop     = 1'b1;
                            acc_nxt = stack_top;
                        end
                        OP_AND_WIDE_CONSTANT: begin
                            acc_nxt = acc_r & op_const;
                            zf_nxt  = is_zero(acc_nxt);
                            nf_nxt  = acc_nxt[ACC_W-1];
                        end
                        default: begin
                            // no operation, load chain kept
                            last_load_nxt = last_load_r;
                        end
                    endcase
                end
            end
            S_RD: begin
                // memory samples the read this cycle
                state_nxt = S_DATA;
            end
            S_DATA: begin
                // read data valid now
                state_nxt = S_IDLE;
                ready_nxt = 1'b1;
                done_nxt  = 1'b1;
                case (op_r)
                    OP_LOAD_WORD: begin
                        push    = last_load_r;
                        last_load_nxt = 1'b1;
                        acc_nxt = {WORD_RST, wmem_rdata};
                        zf_nxt  = is_zero(acc_nxt);
                    end
                    OP_AND_WORD: begin
                        acc_nxt = {WORD_RST, acc_r[WORD_W-1:0] & wmem_rdata};
                        zf_nxt  = is_zero(acc_nxt);
                    end
                    OP_LOW_BYTE_OUTPUT: begin
                        wdata_nxt = {wmem_rdata[15:8], acc_r[7:0]};
                        wr_nxt    = 1'b1;
                    end
                    OP_HIGH_BYTE_OUTPUT: begin
                        wdata_nxt = {acc_r[15:8], wmem_rdata[7:0]};
                        wr_nxt    = 1'b1;
                    end
                    default: begin
                        // nothing left to do
                        wr_nxt = 1'b0;
                    end
                endcase
            end
            S_BITS: begin
                // one discrete bit per cycle at consecutive addresses
                baddr_nxt = bmem_addr_r + ADDR_W'(1);
                bdat_nxt  = acc_r[cnt_r[4:0]];
                bwr_nxt   = 1'b1;
                cnt_nxt   = cnt_r + BITS_MIN;
                if (cnt_nxt == nbits_r) begin
                    state_nxt = S_IDLE;
                    ready_nxt = 1'b1;
                    done_nxt  = 1'b1;
                end
            end
            default: begin
                state_nxt = S_IDLE;
                ready_nxt = 1'b1;
            end
        endcase
    end

    // all state and outputs registered
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_r                <= S_IDLE;
            op_r                   <= OP_NOP;
            cnt_r                  <= CNT_RST;
            nbits_r                <= CNT_RST;
            last_load_r            <= 1'b0;
            op_ready_r             <= 1'b1;
            op_done_r              <= 1'b0;
            wmem_addr_r            <= ADDR_RST;
            wmem_rd_en_r           <= 1'b0;
            wmem_wr_en_r           <= 1'b0;
            wmem_wdata_r           <= WORD_RST;
            bmem_addr_r            <= ADDR_RST;
            bmem_wr_en_r           <= 1'b0;
            bmem_wdata_r           <= 1'b0;
            acc_r                  <= ACC_RST;
            zero_result_flag_r     <= 1'b0;
            negative_result_flag_r <= 1'b0;
        end else begin
            state_r                <= state_nxt;
            op_r                   <= op_nxt;
            cnt_r                  <= cnt_nxt;
            nbits_r                <= nbits_nxt;
            last_load_r            <= last_load_nxt;
            op_ready_r             <= ready_nxt;
            op_done_r              <= done_nxt;
            wmem_addr_r            <= waddr_nxt;
            wmem_rd_en_r           <= rd_nxt;
            wmem_wr_en_r           <= wr_nxt;
            wmem_wdata_r           <= wdata_nxt;
            bmem_addr_r            <= baddr_nxt;
            bmem_wr_en_r           <= bwr_nxt;
            bmem_wdata_r           <= bdat_nxt;
            acc_r                  <= acc_nxt;
            zero_result_flag_r     <= zf_nxt;
            negative_result_flag_r <= nf_nxt;
        end
    end
endmodule : accumulator_output_and_logic_unit

// ===== acc_unit_props.sv
`timescale 1ns/1ns
// port-level checks on op handshake, memory traffic and status flags
module acc_unit_props
    import acc_unit_pkg::*;
(
    // clock and reset
    input wire logic               core_clk,
    input wire logic               sys_rst,
    // operation request
    input wire logic               op_valid,
    input wire acc_unit_pkg::op_t  op_code,
    input wire logic [15:0]        op_addr,
    input wire logic [31:0]        op_const,
    input wire logic               op_ready_r,
    input wire logic               op_done_r,
    // memories
    input wire logic [15:0]        wmem_addr_r,
    input wire logic               wmem_rd_en_r,
    input wire logic               wmem_wr_en_r,
    input wire logic [15:0]        wmem_wdata_r,
    input wire logic [15:0]        bmem_addr_r,
    input wire logic               bmem_wr_en_r,
    // accumulator and status
    input wire logic [31:0]        acc_r,
    input wire logic               zero_result_flag_r,
    input wire logic               negative_result_flag_r
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic take;  // request accepted at this edge
    assign take = op_valid && op_ready_r;

    a_wide_and_val: assert property (take && op_code == OP_AND_WIDE_CONSTANT
        |=> acc_r == ($past(acc_r) & $past(op_const))) else $error("wide and value wrong");
    a_wide_zero_flag: assert property (take && op_code == OP_AND_WIDE_CONSTANT
        |=> zero_result_flag_r == (acc_r == 32'h0)) else $error("wide and zero flag wrong");
    a_wide_neg_flag: assert property (take && op_code == OP_AND_WIDE_CONSTANT
        |=> negative_result_flag_r == acc_r[31]) else $error("negative flag wrong");
    a_neg_flag_hold: assert property ($changed(negative_result_flag_r)
        |-> $past(take && op_code == OP_AND_WIDE_CONSTANT)) else $error("negative flag moved");
    a_idx_write: assert property (take && op_code == OP_INDEXED_WORD_OUTPUT
        |=> wmem_wr_en_r && wmem_addr_r == $past(op_addr) + $past(acc_r[15:0]))
        else $error("indexed write address wrong");
    a_idx_upper_clr: assert property (take && op_code == OP_INDEXED_WORD_OUTPUT
        |=> acc_r == {16'h0, $past(acc_r[15:0])}) else $error("indexed upper half kept");
    a_word_out_data: assert property (take && op_code == OP_WORD_OUTPUT
        |=> wmem_wr_en_r && wmem_wdata_r == $past(acc_r[15:0])) else $error("word output wrong");
    a_and_word_seq: assert property (take && op_code == OP_AND_WORD
        |=> wmem_rd_en_r && !op_ready_r ##1 !op_ready_r ##1 op_done_r && op_ready_r)
        else $error("word and sequence wrong");
    a_and_word_zero: assert property (take && op_code == OP_AND_WORD
        |-> ##3 zero_result_flag_r == (acc_r == 32'h0)) else $error("word and zero flag wrong");
    a_low_byte_data: assert property (take && op_code == OP_LOW_BYTE_OUTPUT
        |-> ##3 wmem_wr_en_r && wmem_wdata_r[7:0] == $past(acc_r[7:0], 3))
        else $error("low byte data wrong");
    a_bit_addr_step: assert property (bmem_wr_en_r && $past(bmem_wr_en_r)
        && !$past(op_ready_r) |-> bmem_addr_r == $past(bmem_addr_r) + 16'h0001)
        else $error("bit address not consecutive");
endmodule : acc_unit_props

bind accumulator_output_and_logic_unit acc_unit_props acc_unit_props_i (
    .core_clk               (core_clk),
    .sys_rst                (sys_rst),
    .op_valid               (op_valid),
    .op_code                (op_code),
    .op_addr                (op_addr),
    .op_const               (op_const),
    .op_ready_r             (op_ready_r),
    .op_done_r              (op_done_r),
    .wmem_addr_r            (wmem_addr_r),
    .wmem_rd_en_r           (wmem_rd_en_r),
    .wmem_wr_en_r           (wmem_wr_en_r),
    .wmem_wdata_r           (wmem_wdata_r),
    .bmem_addr_r            (bmem_addr_r),
    .bmem_wr_en_r           (bmem_wr_en_r),
    .acc_r                  (acc_r),
    .zero_result_flag_r     (zero_result_flag_r),
    .negative_result_flag_r (negative_result_flag_r)
);

// ===== word_bit_mem_model.sv
`timescale 1ns/1ns
// data word memory with one-cycle read, plus discrete bit memory
module word_bit_mem_model (
    // clock
    input wire logic         core_clk,
    // word memory
    input wire logic [15:0]  wmem_addr_r,
    input wire logic         wmem_rd_en_r,
    input wire logic         wmem_wr_en_r,
    input wire logic [15:0]  wmem_wdata_r,
    output logic     [15:0]  wmem_rdata,
    // bit memory
    input wire logic [15:0]  bmem_addr_r,
    input wire logic         bmem_wr_en_r,
    input wire logic         bmem_wdata_r
);
    logic [15:0] words [0:255];  // word store, low address byte decoded
    logic        bits  [0:255];  // discrete store, low address byte decoded
    // writes land at the edge; read data stands for one cycle only
    always @(posedge core_clk) begin
        if (wmem_wr_en_r) words[wmem_addr_r[7:0]] <= wmem_wdata_r;
        if (bmem_wr_en_r) bits[bmem_addr_r[7:0]] <= bmem_wdata_r;
        // idle bus flips so stale data is never mistaken for an answer
        if (wmem_rd_en_r) wmem_rdata <= words[wmem_addr_r[7:0]];
        else wmem_rdata <= ~wmem_rdata;
    end
endmodule : word_bit_mem_model

// ===== tb_accumulator_output_and_logic_unit.sv
`timescale 1ns/1ns
module tb_accumulator_output_and_logic_unit;
    import acc_unit_pkg::*;
    logic        core_clk, sys_rst, op_valid, op_ready_r, op_done_r;
    op_t         op_code;
    logic [15:0] op_addr, wmem_addr_r, wmem_wdata_r, wmem_rdata, bmem_addr_r;
    logic [31:0] op_const, acc_r;
    logic        wmem_rd_en_r, wmem_wr_en_r, bmem_wr_en_r, bmem_wdata_r;
    logic        zero_result_flag_r, negative_result_flag_r;
    int          error_cnt = 0;
    int          checked = 0;
    accumulator_output_and_logic_unit accumulator_output_and_logic_unit_i (
        .core_clk               (core_clk),
        .sys_rst                (sys_rst),
        .op_valid               (op_valid),
        .op_code                (op_code),
        .op_addr                (op_addr),
        .op_const               (op_const),
        .op_ready_r             (op_ready_r),
        .op_done_r              (op_done_r),
        .wmem_addr_r            (wmem_addr_r),
        .wmem_rd_en_r           (wmem_rd_en_r),
        .wmem_wr_en_r           (wmem_wr_en_r),
        .wmem_wdata_r           (wmem_wdata_r),
        .wmem_rdata             (wmem_rdata),
        .bmem_addr_r            (bmem_addr_r),
        .bmem_wr_en_r           (bmem_wr_en_r),
        .bmem_wdata_r           (bmem_wdata_r),
        .acc_r                  (acc_r),
        .zero_result_flag_r     (zero_result_flag_r),
        .negative_result_flag_r (negative_result_flag_r)
    );
    word_bit_mem_model word_bit_mem_model_i (
        .core_clk               (core_clk),
        .wmem_addr_r            (wmem_addr_r),
        .wmem_rd_en_r           (wmem_rd_en_r),
        .wmem_wr_en_r           (wmem_wr_en_r),
        .wmem_wdata_r           (wmem_wdata_r),
        .wmem_rdata             (wmem_rdata),
        .bmem_addr_r            (bmem_addr_r),
        .bmem_wr_en_r           (bmem_wr_en_r),
        .bmem_wdata_r           (bmem_wdata_r)
    );
    always #25 core_clk = ~core_clk;  // 20 MHz
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic print_verdict;
        $display("checks=%0d errors=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict
    // one request from a falling edge where ready is high, then wait for done
    task automatic run_op(input op_t c, input logic [15:0] a, input logic [31:0] k);
        int i;
        op_code = c;
        op_addr = a;
        op_const = k;
        op_valid = 1'b1;
        @(negedge core_clk);
        op_valid = 1'b0;
        for (i = 0; i < 60 && op_done_r !== 1'b1; i++) @(negedge core_clk);
        if (i == 60) begin
            error_cnt++;
            print_verdict();
        end
        @(negedge core_clk);
    endtask : run_op
    function automatic logic [31:0] flags;
        return {30'h0, zero_result_flag_r, negative_result_flag_r};
    endfunction : flags
    // load chain pushes, indexed output and pop
    task automatic t_index;
        word_bit_mem_model_i.words[8'h10] = 16'h3544;
        run_op(OP_LOAD_WORD, 16'h0010, 32'h0);
        run_op(OP_LOAD_ADDR, 16'h0000, 32'h0100_0025);
        chk(acc_r, 32'h0004_0015);
        run_op(OP_INDEXED_WORD_OUTPUT, 16'h0040, 32'h0);
        chk(acc_r, 32'h0000_0015);
        chk({16'h0, word_bit_mem_model_i.words[8'h55]}, 32'h3544);
        run_op(OP_POP, 16'h0000, 32'h0);
        chk(acc_r, 32'h0000_3544);
        // a load after a pop starts a new chain, so nothing is pushed
        run_op(OP_LOAD_WORD, 16'h0010, 32'h0);
        run_op(OP_POP, 16'h0000, 32'h0);
        chk(acc_r, 32'h0);
    endtask : t_index
    // formatted output at smallest, middle and largest counts
    task automatic t_formatted;
        int n;
        run_op(OP_LOAD_ADDR, 16'h0000, 32'h7654_3210);
        chk(acc_r, 32'h00FA_C688);
        for (int j = 0; j < 3; j++) begin
            n = (j == 0) ? 1 : (j == 1) ? 7 : 32;
            for (int i = 0; i < 40; i++) word_bit_mem_model_i.bits[8'h80 + i] = 1'bz;
            run_op(OP_FORMATTED_BIT_OUT, 16'h0080, n);
            for (int i = 0; i < n; i++)
                chk({31'h0, word_bit_mem_model_i.bits[8'h80 + i]}, (32'h00FA_C688 >> i) & 32'h1);
            chk({31'h0, word_bit_mem_model_i.bits[8'h80 + n]}, {31'h0, 1'bz});
        end
    endtask : t_formatted
    // byte outputs merge into the old word
    task automatic t_bytes;
        word_bit_mem_model_i.words[8'h20] = 16'h1234;
        word_bit_mem_model_i.words[8'h21] = 16'h1234;
        run_op(OP_LOW_BYTE_OUTPUT, 16'h0020, 32'h0);
        chk({16'h0, word_bit_mem_model_i.words[8'h20]}, 32'h1288);
        run_op(OP_HIGH_BYTE_OUTPUT, 16'h0020, 32'h0);
        chk({16'h0, word_bit_mem_model_i.words[8'h20]}, 32'hC688);
        run_op(OP_HIGH_BYTE_OUTPUT, 16'h0021, 32'h0);
        chk({16'h0, word_bit_mem_model_i.words[8'h21]}, 32'hC634);
        chk(acc_r, 32'h00FA_C688);
    endtask : t_bytes
    // word and, wide and, and flag persistence
    task automatic t_ands;
        word_bit_mem_model_i.words[8'h30] = 16'h0F0F;
        word_bit_mem_model_i.words[8'h31] = 16'hF000;
        run_op(OP_AND_WORD, 16'h0030, 32'h0);
        chk(acc_r, 32'h0000_0608);
        chk(flags(), 32'h0);
        run_op(OP_AND_WORD, 16'h0031, 32'h0);
        chk(flags(), 32'h2);
        word_bit_mem_model_i.words[8'h50] = 16'hFFFF;
        run_op(OP_WORD_OUTPUT, 16'h0050, 32'h0);
        run_op(OP_NOP, 16'h0000, 32'h0);
        chk({16'h0, word_bit_mem_model_i.words[8'h50]}, 32'h0);
        chk(flags(), 32'h2);
        run_op(OP_LOAD_ADDR, 16'h0000, 32'h7654_3210);
        chk(flags(), 32'h0);
        run_op(OP_AND_WIDE_CONSTANT, 16'h0000, 32'hFF00_F0F0);
        chk(acc_r, 32'h0000_C080);
        chk(flags(), 32'h0);
        run_op(OP_AND_WIDE_CONSTANT, 16'h0000, 32'hFF3F_0F0F);
        chk(acc_r, 32'h0);
        chk(flags(), 32'h2);
    endtask : t_ands
    // hang guard
    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        print_verdict();
    end
    initial begin
        core_clk = 1'b0;
        sys_rst = 1'b1;
        op_valid = 1'b0;
        op_code = OP_NOP;
        op_addr = 16'h0;
        op_const = 32'h0;
        repeat (5) @(negedge core_clk);
        sys_rst = 1'b0;
        @(negedge core_clk);
        chk({acc_r[30:0], op_ready_r}, 32'h1);
        chk(flags(), 32'h0);
        t_index();
        t_formatted();
        t_bytes();
        t_ands();
        print_verdict();
    end
endmodule : tb_accumulator_output_and_logic_unit
